// ### include/breaker_seq_pkg.sv
// Constants, types and timing for the breaker command sequencer
package breaker_seq_pkg;

  localparam int unsigned NUM_DEV = 4;
  localparam int unsigned DEV_W = 2;
  localparam int unsigned NUM_REMOTE = 3;
  localparam int unsigned TMR_W = 32;

  // Timing, figures in their own units
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned ENTER_TIMEOUT_S = 60;
  localparam int unsigned WATCHDOG_MS = 1000;
  localparam int unsigned ENTER_TIMEOUT_CYC = ENTER_TIMEOUT_S * CLK_HZ;
  localparam int unsigned WATCHDOG_CYC = WATCHDOG_MS * (CLK_HZ / 1000);

  localparam logic AUTH_LOCAL = 1'b0;
  localparam logic AUTH_REMOTE = 1'b1;

  typedef enum logic [1:0] {SRC_KEYPAD, SRC_TOOL, SRC_SCADA, SRC_AUTO} src_e;

  typedef enum logic [2:0] {
    PS_STATUS_SET, PS_STATUS_CLR, PS_AUTH, PS_PARAM, PS_SCADA_BLK, PS_BUF_RESET,
    PS_OUT_BLK, PS_IN_BLK
  } pseudo_e;

  typedef enum logic [3:0] {
    REJ_NONE, REJ_ACCESS, REJ_AUTH, REJ_POSITION, REJ_ZONE, REJ_SYSTEM, REJ_DOUBLE,
    REJ_PROT, REJ_SETTING, REJ_NO_OUTPUT, REJ_OUT_BLOCK, REJ_IN_PROGRESS, REJ_ONE_OF_N,
    REJ_WATCHDOG
  } rej_e;

  typedef struct packed {
    logic valid;
    logic pseudo;
    pseudo_e op;
    logic val;
    logic [DEV_W-1:0] dev;
    logic close;
  } cmd_s;

  typedef struct packed {
    logic auth;
    logic pos;
    logic zone;
    logic sys;
    logic dbl;
    logic prot;
  } ilk_cfg_s;

  typedef struct packed {
    logic assigned;
    logic has_fb;
    logic [1:0] relay_grp;
    ilk_cfg_s ilk;
  } dev_cfg_s;

  typedef struct packed {
    logic ctrl;
    logic open;
    logic close;
    logic enter;
    logic esc;
    logic next;
  } key_s;

endpackage : breaker_seq_pkg

// ### logic/breaker_command_sequencer.sv
// Breaker command sequencer: keypad handshake, command checks, output drive
// Function
// - Commands come from keypad, configuration tool, SCADA and automatic functions.
// - Open and close keys act only after the control key shows the control display.
// - Open or close blinks the device in target position and prompts; enter confirms.
// - After first enter a security check runs; a second enter executes.
// - No enter within one minute cancels the pending selection.
// - Escape cancels the pending selection until the second enter; a command waiting to issue is not cancelled.
// - Success shows new position and executed; feedback commands also show feedback OK.
// - Interlock refusal shows its reason and needs enter before further keypad commands.
// - Control commands drive open or close binary outputs.
// - Pseudo commands set internal states and never drive binary outputs.
// - Access rights checked first, then interlocked or non-interlocked mode decides.
// - Per-device selectable checks: authority, position, zone, system, protection; double is always checked.
// - Watchdog aborts a command when initiation to contact closure reaches one second.
// - Commands are denied while a setting modification is in progress.
// - Commands to switchgear without an assigned output are denied.
// - Commands are denied while an output block for that switchgear is active.
// - Only one command per switchgear at a time; a further one is refused.
// - A second command on an already initiated shared output relay is refused.
// - Release only after all enabled checks pass; execution monitored afterwards.
// - Protection blocking refuses close while any element is picked up; open passes.
// - Position check refuses a command already in the requested position, any mode.
`timescale 1ns/1ps
module breaker_command_sequencer
  import breaker_seq_pkg::*;
#(
  parameter int unsigned ENTER_TO_CYC = ENTER_TIMEOUT_CYC,
  parameter int unsigned WD_CYC = WATCHDOG_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire key_s keys_i,
  input wire cmd_s [NUM_REMOTE-1:0] remote_cmd_i,
  input wire logic [3:0] access_ok_i,
  input wire logic interlock_mode_i,
  input wire logic setting_mod_i,
  input wire dev_cfg_s [NUM_DEV-1:0] dev_cfg_i,
  input wire logic [NUM_DEV-1:0] pos_closed_i,
  input wire logic [NUM_DEV-1:0] user_interlock_logic_ok_i,
  input wire logic system_ok_i,
  input wire logic pickup_i,
  output logic [NUM_REMOTE-1:0] remote_taken_o,
  output logic [NUM_DEV-1:0] out_open_o,
  output logic [NUM_DEV-1:0] out_close_o,
  output logic done_o,
  output logic reject_o,
  output rej_e reject_code_o,
  output src_e event_src_o,
  output logic ctrl_display_o,
  output logic blink_o,
  output logic confirm_o,
  output logic confirm2_o,
  output logic [DEV_W-1:0] sel_dev_o,
  output logic sel_close_o,
  output logic executed_o,
  output logic feedback_ok_o,
  output logic error_o,
  output rej_e error_code_o,
  output logic authority_o,
  output logic param_set_o,
  output logic scada_block_o,
  output logic buf_reset_o,
  output logic [NUM_DEV-1:0] out_block_o,
  output logic [NUM_DEV-1:0] in_block_o,
  output logic [NUM_DEV-1:0] pos_eff_o
);

  typedef enum {K_IDLE, K_CTRL, K_CONFIRM1, K_SECURE, K_CONFIRM2, K_EXEC, K_ERROR} kp_state_e;
  typedef enum {E_IDLE, E_RUN} eng_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Key synchroniser, edges taken only from the second stage
  key_s key_s1_r, key_s2_r, key_prev_r;
  key_s press;

  always_comb
  begin
    press = key_s2_r & ~key_prev_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      key_s1_r <= '0;
      key_s2_r <= '0;
      key_prev_r <= '0;
    end
    else
    begin
      key_s1_r <= keys_i;
      key_s2_r <= key_s1_r;
      key_prev_r <= key_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State shared by the checks
  eng_state_e eng_r, eng_nxt;
  cmd_s cur_r, cur_nxt;
  logic authority_r, authority_nxt;
  logic [NUM_DEV-1:0] out_blk_r, out_blk_nxt, ovr_en_r, ovr_en_nxt, ovr_val_r, ovr_val_nxt;
  logic [NUM_DEV-1:0] pos_eff;

  always_comb
  begin
    for (int i = 0; i < NUM_DEV; i++)
    begin
      pos_eff[i] = ovr_en_r[i] ? ovr_val_r[i] : pos_closed_i[i];
    end
  end

  function automatic rej_e check_cmd(input cmd_s c, input src_e s);
    dev_cfg_s cfg;
    cfg = dev_cfg_i[c.dev];
    if (!access_ok_i[s])
      return REJ_ACCESS;
    if (c.pseudo)
      return REJ_NONE; // Internal actions bypass interlocking
    if (setting_mod_i)
      return REJ_SETTING;
    if (!cfg.assigned)
      return REJ_NO_OUTPUT;
    if (out_blk_r[c.dev])
      return REJ_OUT_BLOCK;
    if (eng_r == E_RUN)
    begin
      if (cur_r.dev == c.dev)
        return REJ_IN_PROGRESS;
      if (dev_cfg_i[cur_r.dev].relay_grp == cfg.relay_grp)
        return REJ_ONE_OF_N;
      // Single engine: parallel commands are always refused
      return REJ_DOUBLE;
    end
    if (cfg.ilk.pos && (pos_eff[c.dev] == c.close))
      return REJ_POSITION;
    if (interlock_mode_i)
    begin
      if (cfg.ilk.auth && (s == SRC_KEYPAD) && (authority_r != AUTH_LOCAL))
        return REJ_AUTH;
      if (cfg.ilk.auth && (s != SRC_KEYPAD) && (s != SRC_AUTO) && (authority_r != AUTH_REMOTE))
        return REJ_AUTH;
      if (cfg.ilk.zone && !user_interlock_logic_ok_i[c.dev])
        return REJ_ZONE;
      if (cfg.ilk.sys && !system_ok_i)
        return REJ_SYSTEM;
      if (cfg.ilk.prot && c.close && pickup_i)
        return REJ_PROT;
    end
    return REJ_NONE;
  endfunction : check_cmd

  ////////////////////////////////////////////////////////////////////////////////
  // Keypad handshake
  kp_state_e kp_r, kp_nxt;
  logic [TMR_W-1:0] kp_tmr_r, kp_tmr_nxt;
  logic [DEV_W-1:0] sel_r, sel_nxt;
  logic sel_close_r, sel_close_nxt, executed_r, executed_nxt, fbok_r, fbok_nxt;
  rej_e err_r, err_nxt;
  cmd_s kp_cmd;
  rej_e kp_chk;
  logic take_kp, ev_done, ev_rej, ev_fbok;
  rej_e ev_code;
  src_e ev_src;
  logic disp_r, disp_nxt, blink_r, blink_nxt, cfm1_r, cfm1_nxt;
  logic cfm2_r, cfm2_nxt, err_on_r, err_on_nxt;

  always_comb
  begin
    kp_cmd = '{valid: 1'b1, pseudo: 1'b0, op: PS_STATUS_SET, val: 1'b0, dev: sel_r,
               close: sel_close_r};
    kp_chk = check_cmd(kp_cmd, SRC_KEYPAD);
    kp_nxt = kp_r;
    kp_tmr_nxt = '0;
    sel_nxt = sel_r;
    sel_close_nxt = sel_close_r;
    err_nxt = err_r;
    executed_nxt = executed_r;
    fbok_nxt = fbok_r;
    if (press != '0)
    begin
      executed_nxt = 1'b0;
      fbok_nxt = 1'b0;
    end
    case (kp_r)
      K_IDLE:
        if (press.ctrl)
          kp_nxt = K_CTRL;
      K_CTRL:
        if (press.ctrl)
          kp_nxt = K_IDLE;
        else if (press.next)
          sel_nxt = sel_r + 1'b1;
        else if (press.open || press.close)
        begin
          sel_close_nxt = press.close;
          kp_nxt = K_CONFIRM1;
        end
      K_CONFIRM1, K_CONFIRM2:
      begin
        kp_tmr_nxt = kp_tmr_r + 1'b1;
        if (press.esc)
          kp_nxt = K_CTRL;
        else if (press.enter)
        begin
          kp_tmr_nxt = '0;
          kp_nxt = (kp_r == K_CONFIRM1) ? K_SECURE : K_EXEC;
        end
        else if (kp_tmr_r == TMR_W'(ENTER_TO_CYC - 1))
          kp_nxt = K_CTRL;
      end
      K_SECURE:
        if (press.esc)
          kp_nxt = K_CTRL;
        else if (kp_chk != REJ_NONE)
        begin
          err_nxt = kp_chk;
          kp_nxt = K_ERROR;
        end
        else
          kp_nxt = K_CONFIRM2;
      K_EXEC:
        if (ev_done && ev_src == SRC_KEYPAD)
        begin
          executed_nxt = 1'b1;
          fbok_nxt = ev_fbok;
          kp_nxt = K_CTRL;
        end
        else if (ev_rej && ev_src == SRC_KEYPAD)
        begin
          err_nxt = ev_code;
          kp_nxt = K_ERROR;
        end
        else if (press.esc && !take_kp && eng_r == E_IDLE)
          kp_nxt = K_CTRL;
      K_ERROR:
        if (press.enter)
        begin
          err_nxt = REJ_NONE;
          kp_nxt = K_CTRL;
        end
      default:
        kp_nxt = K_IDLE;
    endcase
    // Display flags decoded from the next state so the pins come straight off flops
    disp_nxt = (kp_nxt != K_IDLE);
    blink_nxt = (kp_nxt == K_CONFIRM1) || (kp_nxt == K_SECURE) || (kp_nxt == K_CONFIRM2);
    cfm1_nxt = (kp_nxt == K_CONFIRM1);
    cfm2_nxt = (kp_nxt == K_CONFIRM2);
    err_on_nxt = (kp_nxt == K_ERROR);
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      kp_r <= K_IDLE;
      kp_tmr_r <= '0;
      sel_r <= '0;
      sel_close_r <= 1'b0;
      err_r <= REJ_NONE;
      executed_r <= 1'b0;
      fbok_r <= 1'b0;
      disp_r <= 1'b0;
      blink_r <= 1'b0;
      cfm1_r <= 1'b0;
      cfm2_r <= 1'b0;
      err_on_r <= 1'b0;
    end
    else
    begin
      kp_r <= kp_nxt;
      kp_tmr_r <= kp_tmr_nxt;
      sel_r <= sel_nxt;
      sel_close_r <= sel_close_nxt;
      err_r <= err_nxt;
      executed_r <= executed_nxt;
      fbok_r <= fbok_nxt;
      disp_r <= disp_nxt;
      blink_r <= blink_nxt;
      cfm1_r <= cfm1_nxt;
      cfm2_r <= cfm2_nxt;
      err_on_r <= err_on_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command engine, output drive and internal states
  src_e cur_src_r, cur_src_nxt;
  logic [TMR_W-1:0] wd_r, wd_nxt;
  logic [NUM_DEV-1:0] open_r, open_nxt, close_r, close_nxt, in_blk_r, in_blk_nxt;
  logic [NUM_REMOTE-1:0] taken_r, taken_nxt;
  logic param_r, param_nxt, scada_blk_r, scada_blk_nxt, buf_rst_r, buf_rst_nxt;
  cmd_s cand;
  src_e cand_src;
  rej_e cand_chk;
  logic run_fin;

  always_comb
  begin
    eng_nxt = eng_r;
    cur_nxt = cur_r;
    cur_src_nxt = cur_src_r;
    wd_nxt = '0;
    open_nxt = open_r;
    close_nxt = close_r;
    taken_nxt = '0;
    authority_nxt = authority_r;
    param_nxt = param_r;
    scada_blk_nxt = scada_blk_r;
    buf_rst_nxt = 1'b0;
    out_blk_nxt = out_blk_r;
    in_blk_nxt = in_blk_r;
    ovr_en_nxt = ovr_en_r;
    ovr_val_nxt = ovr_val_r;
    take_kp = 1'b0;
    ev_done = 1'b0;
    ev_rej = 1'b0;
    ev_fbok = 1'b0;
    ev_code = REJ_NONE;
    ev_src = cur_src_r;
    cand = kp_cmd;
    cand_src = SRC_KEYPAD;
    cand.valid = (kp_r == K_EXEC);
    for (int i = NUM_REMOTE - 1; i >= 0; i--)
    begin
      if (!cand.valid || cand_src != SRC_KEYPAD || kp_r != K_EXEC)
      begin
        if (remote_cmd_i[i].valid && !taken_r[i])
        begin
          cand = remote_cmd_i[i];
          cand_src = src_e'(i + 1);
        end
      end
    end
    if (kp_r == K_EXEC)
    begin
      cand = kp_cmd;
      cand_src = SRC_KEYPAD;
    end
    cand_chk = check_cmd(cand, cand_src);
    run_fin = !dev_cfg_i[cur_r.dev].has_fb || (pos_eff[cur_r.dev] == cur_r.close);
    // Watchdog keeps counting while refusals are handed out
    if (eng_r == E_RUN)
    begin
      wd_nxt = wd_r + 1'b1;
    end
    // Ending the running command wins; a waiting request is taken a cycle later
    if (eng_r == E_RUN && (run_fin || wd_r == TMR_W'(WD_CYC - 1)))
    begin
      ev_src = cur_src_r;
      open_nxt = '0;
      close_nxt = '0;
      eng_nxt = E_IDLE;
      if (run_fin)
      begin
        ev_done = 1'b1;
        ev_fbok = dev_cfg_i[cur_r.dev].has_fb;
      end
      else
      begin
        ev_rej = 1'b1;
        ev_code = REJ_WATCHDOG;
      end
    end
    else if (cand.valid && (eng_r == E_IDLE || cand_src != SRC_KEYPAD))
    begin
      ev_src = cand_src;
      if (cand_src == SRC_KEYPAD)
        take_kp = 1'b1;
      else
        taken_nxt[cand_src - 1] = 1'b1;
      if (cand_chk != REJ_NONE)
      begin
        ev_rej = 1'b1;
        ev_code = cand_chk;
      end
      else if (cand.pseudo)
      begin
        ev_done = 1'b1;
        case (cand.op)
          PS_STATUS_SET: begin ovr_en_nxt[cand.dev] = 1'b1; ovr_val_nxt[cand.dev] = cand.val; end
          PS_STATUS_CLR: ovr_en_nxt[cand.dev] = 1'b0;
          PS_AUTH: authority_nxt = cand.val;
          PS_PARAM: param_nxt = cand.val;
          PS_SCADA_BLK: scada_blk_nxt = cand.val;
          PS_BUF_RESET: buf_rst_nxt = 1'b1;
          PS_OUT_BLK: out_blk_nxt[cand.dev] = cand.val;
          PS_IN_BLK: in_blk_nxt[cand.dev] = cand.val;
          default: ev_done = 1'b1;
        endcase
      end
      else
      begin
        // Release only after every enabled check passed
        cur_nxt = cand;
        cur_src_nxt = cand_src;
        open_nxt[cand.dev] = !cand.close;
        close_nxt[cand.dev] = cand.close;
        eng_nxt = E_RUN;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      eng_r <= E_IDLE;
      cur_r <= '0;
      cur_src_r <= SRC_KEYPAD;
      wd_r <= '0;
      open_r <= '0;
      close_r <= '0;
      taken_r <= '0;
      authority_r <= AUTH_LOCAL;
      param_r <= 1'b0;
      scada_blk_r <= 1'b0;
      buf_rst_r <= 1'b0;
      out_blk_r <= '0;
      in_blk_r <= '0;
      ovr_en_r <= '0;
      ovr_val_r <= '0;
      done_o <= 1'b0;
      reject_o <= 1'b0;
      reject_code_o <= REJ_NONE;
      event_src_o <= SRC_KEYPAD;
      pos_eff_o <= '0;
    end
    else
    begin
      eng_r <= eng_nxt;
      cur_r <= cur_nxt;
      cur_src_r <= cur_src_nxt;
      wd_r <= wd_nxt;
      open_r <= open_nxt;
      close_r <= close_nxt;
      taken_r <= taken_nxt;
      authority_r <= authority_nxt;
      param_r <= param_nxt;
      scada_blk_r <= scada_blk_nxt;
      buf_rst_r <= buf_rst_nxt;
      out_blk_r <= out_blk_nxt;
      in_blk_r <= in_blk_nxt;
      ovr_en_r <= ovr_en_nxt;
      ovr_val_r <= ovr_val_nxt;
      done_o <= ev_done;
      reject_o <= ev_rej;
      reject_code_o <= ev_code;
      event_src_o <= ev_src;
      pos_eff_o <= pos_eff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flop outputs
  always_comb
  begin
    remote_taken_o = taken_r;
    out_open_o = open_r;
    out_close_o = close_r;
    ctrl_display_o = disp_r;
    blink_o = blink_r;
    confirm_o = cfm1_r;
    confirm2_o = cfm2_r;
    sel_dev_o = sel_r;
    sel_close_o = sel_close_r;
    executed_o = executed_r;
    feedback_ok_o = fbok_r;
    error_o = err_on_r;
    error_code_o = err_r;
    authority_o = authority_r;
    param_set_o = param_r;
    scada_block_o = scada_blk_r;
    buf_reset_o = buf_rst_r;
    out_block_o = out_blk_r;
    in_block_o = in_blk_r;
  end

endmodule : breaker_command_sequencer

// ### tb/breaker_seq_sva.sv
// Port assertions for the breaker command sequencer
`timescale 1ns/1ps
module breaker_seq_sva
  import breaker_seq_pkg::*;
#(
  parameter int unsigned ENTER_TO_CYC = 50,
  parameter int unsigned WD_CYC = 40
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic interlock_mode_i,
  input wire logic pickup_i,
  input wire dev_cfg_s [NUM_DEV-1:0] dev_cfg_i,
  input wire logic [NUM_DEV-1:0] out_open_o,
  input wire logic [NUM_DEV-1:0] out_close_o,
  input wire logic [NUM_DEV-1:0] out_block_o,
  input wire logic done_o,
  input wire logic reject_o,
  input wire rej_e reject_code_o,
  input wire logic confirm_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  ////////////////////////////////////////////////////////////////////////////
  // Run-length counters; repetition operators would not unroll at these lengths
  logic [TMR_W-1:0] wd_cnt_r, wd_cnt_nxt, cfm_cnt_r, cfm_cnt_nxt;
  logic [NUM_DEV-1:0] outs, asg;
  assign outs = out_open_o | out_close_o;
  always_comb
  begin
    wd_cnt_nxt = (|outs) ? wd_cnt_r + 1 : '0;
    cfm_cnt_nxt = confirm_o ? cfm_cnt_r + 1 : '0;
    for (int d = 0; d < NUM_DEV; d++)
      asg[d] = dev_cfg_i[d].assigned;
  end
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wd_cnt_r <= '0;
      cfm_cnt_r <= '0;
    end
    else
    begin
      wd_cnt_r <= wd_cnt_nxt;
      cfm_cnt_r <= cfm_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_OUT_EXCL: assert property (!(|(out_open_o & out_close_o)))
    else $error("open and close driven together");
  AST_ONE_ACTIVE: assert property ($onehot0(outs))
    else $error("two outputs energised at once");
  AST_ASSIGNED: assert property ((outs & ~asg) == '0)
    else $error("output on unassigned switchgear");
  AST_OUT_BLOCK: assert property ($rose(|outs) |-> (outs & out_block_o) == '0)
    else $error("output released while blocked");
  AST_PROT: assert property ($rose(out_close_o[1]) && $past(interlock_mode_i)
    && dev_cfg_i[1].ilk.prot |-> !$past(pickup_i))
    else $error("close released during pickup");
  AST_WD_BOUND: assert property (wd_cnt_r <= WD_CYC + 1)
    else $error("output held past watchdog");
  AST_WD_OFF: assert property (reject_o && reject_code_o == REJ_WATCHDOG |-> outs == '0)
    else $error("output on at watchdog abort");
  AST_REJ_CODE: assert property (reject_o |-> reject_code_o != REJ_NONE)
    else $error("rejection without a reason");
  AST_RELEASE_END: assert property ($fell(|outs) |-> done_o || reject_o)
    else $error("output dropped with no outcome");
  AST_ENTER_TO: assert property (cfm_cnt_r <= ENTER_TO_CYC + 2)
    else $error("confirmation outlived its timeout");
endmodule : breaker_seq_sva

// ### tb/switchgear_model.sv
// Switchgear model: breaker positions follow the binary outputs
`timescale 1ns/1ps
module switchgear_model
  import breaker_seq_pkg::*;
#(
  parameter int unsigned TRAVEL = 3
) (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [NUM_DEV-1:0] out_open_i,
  input wire logic [NUM_DEV-1:0] out_close_i,
  output logic [NUM_DEV-1:0] pos_closed_o
);
  // Contacts travel only while one coil is held; a stalled mechanism never arrives
  int unsigned travel [NUM_DEV];
  initial pos_closed_o = '0;
  always @(posedge clk_i)
  begin
    for (int d = 0; d < NUM_DEV; d++)
    begin
      if (stall_i || !(out_open_i[d] ^ out_close_i[d]))
        travel[d] <= 0;
      else if (travel[d] >= TRAVEL - 1)
        pos_closed_o[d] <= out_close_i[d];
      else
        travel[d] <= travel[d] + 1;
    end
  end
endmodule : switchgear_model

// ### tb/tb_top.sv
// Self-checking bench for the breaker command sequencer
`timescale 1ns/1ps
module tb_top
  import breaker_seq_pkg::*;
;
  localparam int unsigned ENTER_TO = 50;
  localparam int unsigned WD = 40;
  localparam int KC = 5, KO = 4, KL = 3, KE = 2, KX = 1;
  logic clk_i, resetn_i, interlock_mode_i, setting_mod_i, system_ok_i, pickup_i, stall;
  key_s keys_i;
  cmd_s [NUM_REMOTE-1:0] remote_cmd_i;
  logic [3:0] access_ok_i;
  dev_cfg_s [NUM_DEV-1:0] dev_cfg_i;
  logic [NUM_DEV-1:0] pos_closed_i, user_interlock_logic_ok_i, out_open_o, out_close_o;
  logic [NUM_DEV-1:0] out_block_o, in_block_o, pos_eff_o;
  logic [NUM_REMOTE-1:0] remote_taken_o;
  logic done_o, reject_o, ctrl_display_o, blink_o, confirm_o, confirm2_o, sel_close_o;
  logic executed_o, feedback_ok_o, error_o, authority_o, param_set_o, scada_block_o;
  logic buf_reset_o, ev_done;
  logic [DEV_W-1:0] sel_dev_o;
  rej_e reject_code_o, error_code_o, ev_code;
  src_e event_src_o, ev_src;
  int unsigned fails, total_checks, cycles, ev_cnt, snap;

  breaker_command_sequencer #(.ENTER_TO_CYC(ENTER_TO), .WD_CYC(WD)) u_breaker_command_sequencer (
    .clk_i, .resetn_i, .keys_i, .remote_cmd_i, .access_ok_i, .interlock_mode_i, .setting_mod_i,
    .dev_cfg_i, .pos_closed_i, .user_interlock_logic_ok_i, .system_ok_i, .pickup_i,
    .remote_taken_o, .out_open_o, .out_close_o, .done_o, .reject_o, .reject_code_o,
    .event_src_o, .ctrl_display_o, .blink_o, .confirm_o, .confirm2_o, .sel_dev_o, .sel_close_o,
    .executed_o, .feedback_ok_o, .error_o, .error_code_o, .authority_o, .param_set_o,
    .scada_block_o, .buf_reset_o, .out_block_o, .in_block_o, .pos_eff_o);
  switchgear_model u_switchgear_model (.clk_i, .stall_i(stall), .out_open_i(out_open_o),
    .out_close_i(out_close_o), .pos_closed_o(pos_closed_i));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Outcome pulses are latched so a task called late still sees them
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
    if (done_o || reject_o)
    begin
      ev_cnt <= ev_cnt + 1;
      ev_done <= done_o;
      ev_code <= reject_code_o;
      ev_src <= event_src_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task press(input int k);
    @(posedge clk_i);
    keys_i[k] <= 1'b1;
    repeat (4) @(posedge clk_i);
    keys_i[k] <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : press
  task rst;
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : rst
  task issue(input int i, input logic ps, input logic [2:0] op, input logic val,
             input logic [1:0] dev, input logic cl);
    int n;
    snap = ev_cnt;
    @(posedge clk_i);
    remote_cmd_i[i] <= {1'b1, ps, op, val, dev, cl};
    for (n = 0; n < 100 && remote_taken_o[i] !== 1'b1; n++)
      @(posedge clk_i);
    remote_cmd_i[i].valid <= 1'b0;
    chk("remote_taken_o", 1'b1, remote_taken_o[i]);
  endtask : issue
  task outcome(input logic exp_done, input rej_e code);
    for (int n = 0; n < 400 && ev_cnt == snap; n++)
      @(posedge clk_i);
    chk("event_seen", 1'b1, ev_cnt != snap);
    chk("done_o", exp_done, ev_done);
    if (!exp_done)
      chk("reject_code_o", code, ev_code);
  endtask : outcome
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {resetn_i, setting_mod_i, pickup_i, stall, keys_i, remote_cmd_i} = '0;
    {interlock_mode_i, system_ok_i, access_ok_i, user_interlock_logic_ok_i} = '1;
    for (int d = 0; d < NUM_DEV; d++)
      dev_cfg_i[d] = {d != 3, 1'b1, (d == 2) ? 2'h1 : 2'(d), 6'h3f};
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    press(KL);
    chk("confirm_o", 1'b0, confirm_o);
    press(KC);
    chk("ctrl_display_o", 1'b1, ctrl_display_o);
    press(KL);
    chk("confirm_o", 1'b1, confirm_o & blink_o & sel_close_o);
    press(KE);
    chk("confirm2_o", 1'b1, confirm2_o);
    snap = ev_cnt;
    press(KE);
    outcome(1'b1, REJ_NONE);
    chk("executed_o", 2'h3, {executed_o, feedback_ok_o});
    chk("pos_closed_i", 4'h1, pos_closed_i);
    chk("event_src_o", SRC_KEYPAD, ev_src);
    // Unanswered confirmation expires with nothing released
    rst();
    press(KC);
    press(KO);
    repeat (ENTER_TO + 10) @(posedge clk_i);
    chk("confirm_o", 1'b0, confirm_o);
    chk("pos_closed_i", 4'h1, pos_closed_i);
    rst();
    press(KC);
    press(KO);
    press(KE);
    press(KX);
    chk("confirm2_o", 1'b0, confirm2_o | confirm_o);
    chk("pos_closed_i", 4'h1, pos_closed_i);
    press(0);
    chk("sel_dev_o", 2'h1, sel_dev_o);
    rst();
    press(KC);
    press(KL);
    press(KE);
    chk("error_o", 1'b1, error_o);
    chk("error_code_o", REJ_POSITION, error_code_o);
    press(KO);
    chk("confirm_o", 1'b0, confirm_o);
    press(KE);
    chk("error_o", 1'b0, error_o);
    // Remote sources: every internal operation, then each refusal in turn
    rst();
    for (int op = 0; op < 8; op++)
    begin
      issue(0, 1'b1, 3'(op), 1'b1, 2'h2, 1'b0);
      outcome(1'b1, REJ_NONE);
      chk("outputs", 8'h0, {out_open_o, out_close_o});
    end
    chk("internal_states", 5'h1f, {authority_o, param_set_o, scada_block_o,
      out_block_o[2], in_block_o[2]});
    access_ok_i <= 4'hd;
    issue(0, 1'b0, 3'h0, 1'b0, 2'h1, 1'b1);
    outcome(1'b0, REJ_ACCESS);
    chk("event_src_o", SRC_TOOL, ev_src);
    access_ok_i <= 4'hf;
    setting_mod_i <= 1'b1;
    issue(0, 1'b0, 3'h0, 1'b0, 2'h1, 1'b1);
    outcome(1'b0, REJ_SETTING);
    setting_mod_i <= 1'b0;
    issue(0, 1'b0, 3'h0, 1'b0, 2'h3, 1'b1);
    outcome(1'b0, REJ_NO_OUTPUT);
    issue(0, 1'b0, 3'h0, 1'b0, 2'h2, 1'b1);
    outcome(1'b0, REJ_OUT_BLOCK);
    issue(0, 1'b1, PS_OUT_BLK, 1'b0, 2'h2, 1'b0);
    outcome(1'b1, REJ_NONE);
    for (int m = 1; m >= 0; m--)
    begin
      interlock_mode_i <= m[0];
      issue(0, 1'b0, 3'h0, 1'b0, 2'h1, 1'b0);
      outcome(1'b0, REJ_POSITION);
    end
    interlock_mode_i <= 1'b1;
    user_interlock_logic_ok_i <= 4'hd;
    issue(0, 1'b0, 3'h0, 1'b0, 2'h1, 1'b1);
    outcome(1'b0, REJ_ZONE);
    {user_interlock_logic_ok_i, system_ok_i} <= {4'hf, 1'b0};
    issue(0, 1'b0, 3'h0, 1'b0, 2'h1, 1'b1);
    outcome(1'b0, REJ_SYSTEM);
    {system_ok_i, pickup_i} <= 2'h3;
    issue(0, 1'b0, 3'h0, 1'b0, 2'h1, 1'b1);
    outcome(1'b0, REJ_PROT);
    issue(2, 1'b0, 3'h0, 1'b0, 2'h0, 1'b0);
    outcome(1'b1, REJ_NONE);
    chk("pos_closed_i", 4'h0, pos_closed_i);
    pickup_i <= 1'b0;
    issue(0, 1'b1, PS_AUTH, 1'b0, 2'h0, 1'b0);
    outcome(1'b1, REJ_NONE);
    issue(0, 1'b0, 3'h0, 1'b0, 2'h1, 1'b1);
    outcome(1'b0, REJ_AUTH);
    issue(0, 1'b1, PS_AUTH, 1'b1, 2'h0, 1'b0);
    outcome(1'b1, REJ_NONE);
    // Stalled mechanism: parallel requests refused, then the watchdog aborts
    stall <= 1'b1;
    issue(0, 1'b0, 3'h0, 1'b0, 2'h1, 1'b1);
    chk("out_close_o", 4'h2, out_close_o);
    issue(1, 1'b0, 3'h0, 1'b0, 2'h1, 1'b0);
    outcome(1'b0, REJ_IN_PROGRESS);
    issue(2, 1'b0, 3'h0, 1'b0, 2'h2, 1'b1);
    outcome(1'b0, REJ_ONE_OF_N);
    issue(2, 1'b0, 3'h0, 1'b0, 2'h0, 1'b1);
    outcome(1'b0, REJ_DOUBLE);
    snap = ev_cnt;
    outcome(1'b0, REJ_WATCHDOG);
    chk("out_close_o", 4'h0, out_close_o);
    stall <= 1'b0;
    issue(1, 1'b0, 3'h0, 1'b0, 2'h1, 1'b1);
    outcome(1'b1, REJ_NONE);
    chk("pos_closed_i", 4'h2, pos_closed_i);
    chk("event_src_o", SRC_SCADA, ev_src);
    chk("pos_eff_o", 4'h2, pos_eff_o);
    issue(2, 1'b0, 3'h0, 1'b0, 2'h1, 1'b0);
    outcome(1'b1, REJ_NONE);
    chk("event_src_o", SRC_AUTO, ev_src);
    give_verdict();
  end
endmodule : tb_top

bind breaker_command_sequencer breaker_seq_sva #(.ENTER_TO_CYC(ENTER_TO_CYC), .WD_CYC(WD_CYC))
  u_breaker_seq_sva (.clk_i, .resetn_i, .interlock_mode_i, .pickup_i, .dev_cfg_i, .out_open_o,
  .out_close_o, .out_block_o, .done_o, .reject_o, .reject_code_o, .confirm_o);
